// File: logic/dlwl_ctrl.sv
`timescale 1ns/1ns
module dlwl_ctrl
  import dlwl_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Requests, one-cycle pulses; zqcl_en is a level read in S_MR_LAT
  input wire logic req_dll_off,
  input wire logic req_dll_on,
  input wire logic req_pd_freq,
  input wire logic req_level,
  input wire logic zqcl_en,
  // Status
  output logic busy,
  output logic done,
  output logic dll_is_off,
  output logic slow_clk,
  output logic level_ok,
  output logic [PH_W-1:0] delay_upper,
  output logic [PH_W-1:0] delay_lower,
  // Memory link
  dlwl_if.ctrl link
);
  typedef struct packed {
    dlwl_st_e st;
    dlwl_op_e op;
    logic [3:0] pend;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lock_cnt;
    logic [PH_W-1:0] ph;
    logic slow;
    logic dll_off;
    logic rstn;
    logic ck;
    logic cke;
    logic [3:0] cmd;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic odt;
    logic su;
    logic sl;
    logic soe_n;
    dlwl_lane_s up;
    dlwl_lane_s lo;
    logic ok;
    logic busy;
    logic done;
  } dlwl_ctrl_s;

  localparam dlwl_ctrl_s CTRL_RST = '{st: S_INIT, op: OP_OFF, cnt: T_RST,
    cke: 1'b1, cmd: CMD_NOP, soe_n: 1'b1, busy: 1'b1, default: '0};

  dlwl_ctrl_s ctrl_reg;
  dlwl_ctrl_s ctrl_next;
  logic [1:0] fb_sync;

  function automatic logic [PH_W-1:0] half_of(input logic slow);
    half_of = slow ? HALF_SLOW : HALF_FAST;
  endfunction

  function automatic dlwl_ctrl_s issue(input dlwl_ctrl_s s,
      input logic [3:0] c, input logic [BA_W-1:0] b,
      input logic [ADDR_W-1:0] a);
    issue = s;
    issue.cmd = c;
    issue.ba = b;
    issue.addr = a;
  endfunction

  // A lane that reaches the last delay without a rise locks as not found
  function automatic dlwl_lane_s step_lane(input dlwl_lane_s l,
      input logic fb, input logic [PH_W-1:0] last);
    step_lane = l;
    if (!l.lock) begin
      if (fb && !l.prev) begin
        step_lane.lock = 1'b1;
        step_lane.found = 1'b1;
      end else if (l.delay == last) begin
        step_lane.lock = 1'b1;
      end else begin
        step_lane.delay = l.delay + 1'b1;
      end
      step_lane.prev = fb;
    end
  endfunction

  // Feedback returns with no strobe, so it is a foreign-domain input
  dlwl_sync #(.W(2)) u_fb_sync (
    .clk(sys_clk),
    .rst(rst),
    .en(clk_en),
    .d({link.dq[LANE_W], link.dq[0]}),
    .q(fb_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [PH_W-1:0] last;
    logic tick;
    last = PH_W'((half_of(ctrl_reg.slow) << 1) - 1'b1);
    tick = (ctrl_reg.ph == PH_W'(half_of(ctrl_reg.slow) - 1'b1));
    ctrl_next = ctrl_reg;
    if (clk_en) begin
      ctrl_next.done = 1'b0;
      ctrl_next.pend = ctrl_reg.pend |
        {req_level, req_pd_freq, req_dll_on, req_dll_off};
      ctrl_next.ph = (ctrl_reg.ph >= last) ? '0 : ctrl_reg.ph + 1'b1;
      // One strobe rise per lane, placed by that lane's delay
      ctrl_next.su = (ctrl_reg.st == S_WL_PULSE) && (ctrl_reg.cnt == '0) &&
        (ctrl_reg.ph == ctrl_reg.up.delay);
      ctrl_next.sl = (ctrl_reg.st == S_WL_PULSE) && (ctrl_reg.cnt == '0) &&
        (ctrl_reg.ph == ctrl_reg.lo.delay);
      // Commands change with the falling link clock edge
      if (tick) begin
        ctrl_next = issue(ctrl_next, CMD_NOP, BA_MR0, '0);
        if (ctrl_reg.lock_cnt != '0) begin
          ctrl_next.lock_cnt = ctrl_reg.lock_cnt - 1'b1;
        end
        if (ctrl_reg.cnt != '0) begin
          ctrl_next.cnt = ctrl_reg.cnt - 1'b1;
        end else begin
          case (ctrl_reg.st)
            S_INIT: begin
              ctrl_next.rstn = 1'b1;
              ctrl_next.busy = 1'b0;
              ctrl_next.st = S_IDLE;
            end
            S_IDLE: begin
              ctrl_next.pend = ctrl_next.pend & ~ctrl_reg.pend;
              if (ctrl_reg.pend[3]) begin
                ctrl_next.op = OP_WL;
                ctrl_next.st = S_WL_MR1;
              end else if (ctrl_reg.pend[2]) begin
                ctrl_next.op = OP_PD;
                ctrl_next.st = S_PDE;
              end else if (ctrl_reg.pend[1] && ctrl_reg.dll_off) begin
                ctrl_next.op = OP_ON;
                ctrl_next.st = S_SRE;
              end else if (ctrl_reg.pend[0] && !ctrl_reg.dll_off) begin
                ctrl_next.op = OP_OFF;
                ctrl_next.st = S_OFF_MR1;
              end
              ctrl_next.busy = (ctrl_next.st != S_IDLE);
            end
            S_OFF_MR1: begin
              ctrl_next = issue(ctrl_next, CMD_MRS, BA_MR1, MR1_DLL_DIS);
              ctrl_next.dll_off = 1'b1;
              ctrl_next.cnt = T_MOD;
              ctrl_next.st = S_SRE;
            end
            S_SRE: begin
              ctrl_next = issue(ctrl_next, CMD_REF, BA_MR0, '0);
              ctrl_next.cke = 1'b0;
              ctrl_next.cnt = T_CKSRE;
              ctrl_next.st = S_FREQ;
            end
            S_PDE: begin
              ctrl_next.cke = 1'b0;
              ctrl_next.cnt = T_CKSRE;
              ctrl_next.st = S_FREQ;
            end
            S_FREQ: begin
              // Only reachable with CKE low and ODT low
              case (ctrl_reg.op)
                OP_OFF: ctrl_next.slow = 1'b1;
                OP_ON: ctrl_next.slow = 1'b0;
                default: ctrl_next.slow = !ctrl_reg.slow;
              endcase
              ctrl_next.cnt = T_CKSRX;
              ctrl_next.st = S_EXIT;
            end
            S_EXIT: begin
              ctrl_next.cke = 1'b1;
              ctrl_next.cnt = (ctrl_reg.op == OP_PD) ? T_XP : T_XS;
              case (ctrl_reg.op)
                OP_OFF: ctrl_next.st = S_MR_LAT;
                OP_ON: ctrl_next.st = S_ON_MR1;
                default: ctrl_next.st = S_DLL_RST;
              endcase
            end
            S_ON_MR1: begin
              ctrl_next = issue(ctrl_next, CMD_MRS, BA_MR1, '0);
              ctrl_next.dll_off = 1'b0;
              ctrl_next.cnt = T_MRD;
              ctrl_next.st = S_DLL_RST;
            end
            S_DLL_RST: begin
              ctrl_next = issue(ctrl_next, CMD_MRS, BA_MR0,
                MR0_BASE | MR0_DLL_RST);
              ctrl_next.lock_cnt = T_DLLK;
              ctrl_next.cnt = T_MRD;
              ctrl_next.st = S_MR_LAT;
            end
            S_MR_LAT: begin
              ctrl_next = issue(ctrl_next, CMD_MRS, BA_MR2,
                ctrl_reg.slow ? MR2_SLOW : MR2_FAST);
              ctrl_next.cnt = T_MOD;
              ctrl_next.st = zqcl_en ? S_ZQ : S_LOCK;
            end
            S_ZQ: begin
              ctrl_next = issue(ctrl_next, CMD_ZQCL, BA_MR0, ZQ_LONG);
              ctrl_next.cnt = T_ZQOPER;
              ctrl_next.st = S_LOCK;
            end
            S_LOCK: begin
              // CKE stays high and ODT low until relock has elapsed
              if (ctrl_reg.lock_cnt == '0) begin
                ctrl_next.st = S_DONE;
              end
            end
            S_DONE: begin
              ctrl_next.done = 1'b1;
              ctrl_next.busy = 1'b0;
              ctrl_next.st = S_IDLE;
            end
            S_WL_MR1: begin
              ctrl_next = issue(ctrl_next, CMD_MRS, BA_MR1,
                MR1_LEVEL | (ctrl_reg.dll_off ? MR1_DLL_DIS : '0));
              ctrl_next.cnt = T_MOD;
              ctrl_next.st = S_WL_ODT;
            end
            S_WL_ODT: begin
              ctrl_next.odt = 1'b1;
              ctrl_next.cnt = T_WLDQSEN;
              ctrl_next.st = S_WL_DQS;
            end
            S_WL_DQS: begin
              ctrl_next.soe_n = 1'b0;
              ctrl_next.up = '{lock: 1'b0, found: 1'b0, prev: 1'b1,
                delay: '0};
              ctrl_next.lo = ctrl_next.up;
              ctrl_next.cnt = T_WLMRD;
              ctrl_next.st = S_WL_PULSE;
            end
            S_WL_PULSE: begin
              ctrl_next.cnt = T_WLO;
              ctrl_next.st = S_WL_FB;
            end
            S_WL_FB: begin
              ctrl_next.up = step_lane(ctrl_reg.up, fb_sync[1], last);
              ctrl_next.lo = step_lane(ctrl_reg.lo, fb_sync[0], last);
              ctrl_next.st = (ctrl_next.up.lock && ctrl_next.lo.lock) ?
                S_WL_STOP : S_WL_PULSE;
            end
            S_WL_STOP: begin
              ctrl_next.soe_n = 1'b1;
              ctrl_next.odt = 1'b0;
              ctrl_next.ok = ctrl_reg.up.found && ctrl_reg.lo.found;
              ctrl_next.cnt = T_MOD;
              ctrl_next.st = S_WL_EXIT;
            end
            S_WL_EXIT: begin
              ctrl_next = issue(ctrl_next, CMD_MRS, BA_MR1,
                ctrl_reg.dll_off ? MR1_DLL_DIS : '0);
              ctrl_next.cnt = T_MOD;
              ctrl_next.st = S_DONE;
            end
            default: ctrl_next.st = S_IDLE;
          endcase
        end
      end
      ctrl_next.ck = (ctrl_next.ph < half_of(ctrl_next.slow));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign busy = ctrl_reg.busy;
  assign done = ctrl_reg.done;
  assign dll_is_off = ctrl_reg.dll_off;
  assign slow_clk = ctrl_reg.slow;
  assign level_ok = ctrl_reg.ok;
  assign delay_upper = ctrl_reg.up.delay;
  assign delay_lower = ctrl_reg.lo.delay;

  assign link.ck = ctrl_reg.ck;
  assign link.reset_n = ctrl_reg.rstn;
  assign link.cke = ctrl_reg.cke;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = ctrl_reg.cmd;
  assign link.ba = ctrl_reg.ba;
  assign link.addr = ctrl_reg.addr;
  assign link.odt = ctrl_reg.odt;
  assign link.upper_lane_strobe_pair_o = ctrl_reg.su;
  assign link.lower_lane_strobe_pair_o = ctrl_reg.sl;
  assign link.strobe_oe_n = ctrl_reg.soe_n;
endmodule

// File: logic/dlwl_pkg.sv
package dlwl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Link and counter widths
  localparam int ADDR_W = 13;
  localparam int BA_W = 3;
  localparam int DQ_W = 16;
  localparam int LANE_W = 8;
  localparam int PH_W = 4;
  localparam int CNT_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_ZQCL = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // Mode register selects and bit positions
  localparam logic [BA_W-1:0] BA_MR0 = 3'h0;
  localparam logic [BA_W-1:0] BA_MR1 = 3'h1;
  localparam logic [BA_W-1:0] BA_MR2 = 3'h2;
  localparam int MR1_DLL_BIT = 0;
  localparam int MR1_RTT_BIT0 = 2;
  localparam int MR1_RTT_BIT1 = 6;
  localparam int MR1_LEVEL_BIT = 7;
  localparam int MR1_RTT_BIT2 = 9;
  localparam int MR1_QOFF_BIT = 12;
  localparam int MR0_DLL_RST_BIT = 8;
  localparam int ZQ_LONG_BIT = 10;
  localparam logic [ADDR_W-1:0] MR1_DLL_DIS = ADDR_W'(1) << MR1_DLL_BIT;
  localparam logic [ADDR_W-1:0] MR1_LEVEL = ADDR_W'(1) << MR1_LEVEL_BIT;
  localparam logic [ADDR_W-1:0] MR0_DLL_RST = ADDR_W'(1) << MR0_DLL_RST_BIT;
  localparam logic [ADDR_W-1:0] ZQ_LONG = ADDR_W'(1) << ZQ_LONG_BIT;
  localparam logic [ADDR_W-1:0] MR0_BASE = 13'h0000;
  localparam logic [ADDR_W-1:0] MR2_FAST = 13'h0000;
  localparam logic [ADDR_W-1:0] MR2_SLOW = 13'h0008;

  ////////////////////////////////////////////////////////////////////////////
  // Link timing, in link clock cycles
  localparam logic [CNT_W-1:0] T_RST = 10'h008;
  localparam logic [CNT_W-1:0] T_MOD = 10'h00C;
  localparam logic [CNT_W-1:0] T_MRD = 10'h004;
  localparam logic [CNT_W-1:0] T_XS = 10'h018;
  localparam logic [CNT_W-1:0] T_XP = 10'h004;
  localparam logic [CNT_W-1:0] T_CKSRE = 10'h005;
  localparam logic [CNT_W-1:0] T_CKSRX = 10'h005;
  localparam logic [CNT_W-1:0] T_DLLK = 10'h200;
  localparam logic [CNT_W-1:0] T_ZQOPER = 10'h100;
  localparam logic [CNT_W-1:0] T_WLDQSEN = 10'h019;
  localparam logic [CNT_W-1:0] T_WLMRD = 10'h028;
  localparam logic [CNT_W-1:0] T_WLO = 10'h00A;

  // Link clock half periods, in system clock cycles
  localparam logic [PH_W-1:0] HALF_FAST = 4'h2;
  localparam logic [PH_W-1:0] HALF_SLOW = 4'h4;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {OP_OFF, OP_ON, OP_PD, OP_WL} dlwl_op_e;

  typedef enum logic [4:0] {
    S_INIT, S_IDLE, S_OFF_MR1, S_SRE, S_PDE, S_FREQ, S_EXIT, S_ON_MR1,
    S_DLL_RST, S_MR_LAT, S_ZQ, S_LOCK, S_DONE, S_WL_MR1, S_WL_ODT,
    S_WL_DQS, S_WL_PULSE, S_WL_FB, S_WL_STOP, S_WL_EXIT
  } dlwl_st_e;

  typedef struct packed {
    logic lock;
    logic found;
    logic prev;
    logic [PH_W-1:0] delay;
  } dlwl_lane_s;

endpackage

// File: logic/dlwl_if.sv
`timescale 1ns/1ns
interface dlwl_if;
  import dlwl_pkg::*;

  logic ck;
  logic reset_n;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic odt;
  logic upper_lane_strobe_pair_o;
  logic lower_lane_strobe_pair_o;
  logic strobe_oe_n;
  logic [DQ_W-1:0] dq_o;
  logic dq_oe_n;
  // Resolved pin levels; an undriven pin reads low
  logic upper_lane_strobe_pair;
  logic lower_lane_strobe_pair;
  logic [DQ_W-1:0] dq;

  assign upper_lane_strobe_pair = !strobe_oe_n && upper_lane_strobe_pair_o;
  assign lower_lane_strobe_pair = !strobe_oe_n && lower_lane_strobe_pair_o;
  assign dq = dq_oe_n ? '0 : dq_o;

  modport ctrl (
    output ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
    output upper_lane_strobe_pair_o, lower_lane_strobe_pair_o, strobe_oe_n,
    input dq
  );

  modport dram (
    input ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
    input upper_lane_strobe_pair, lower_lane_strobe_pair,
    output dq_o, dq_oe_n
  );
endinterface

// File: logic/dlwl_sync.sv
`timescale 1ns/1ns
module dlwl_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dlwl_sync_s;

  dlwl_sync_s sync_reg;
  dlwl_sync_s sync_next;

  always_comb begin
    sync_next = sync_reg;
    if (en) begin
      sync_next.meta = d;
      sync_next.stable = sync_reg.meta;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.stable;
endmodule

// File: logic/dlwl_dram.sv
`timescale 1ns/1ns
module dlwl_dram
  import dlwl_pkg::*;
(
  // System side
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Status, synchronised to sys_clk
  output logic dll_enabled,
  output logic level_mode,
  output logic in_self_refresh,
  output logic clock_ignored,
  output logic strobe_term_on,
  output logic data_term_on,
  // Memory link
  dlwl_if.dram link
);
  typedef struct packed {
    logic dll_off;
    logic level;
    logic qoff;
    logic rtt_nom;
    logic sr;
    logic pd;
    logic cke_q;
    logic ignore;
    logic [CNT_W-1:0] cnt;
    logic dq_oe_n;
    logic sterm;
    logic dterm;
  } dlwl_dram_s;

  localparam dlwl_dram_s DRAM_RST = '{cke_q: 1'b1, dq_oe_n: 1'b1,
    default: '0};

  dlwl_dram_s dram_reg;
  dlwl_dram_s dram_next;
  logic link_rst;
  logic en_ck;
  logic fb_upper;
  logic fb_lower;
  logic [3:0] cmd;

  assign link_rst = !link.reset_n;
  assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};

  // Freeze request carried into the link clock domain
  dlwl_sync #(.W(1)) u_en_sync (
    .clk(link.ck),
    .rst(link_rst),
    .en(1'b1),
    .d(clk_en),
    .q(en_ck)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    dram_next = dram_reg;
    if (en_ck) begin
      dram_next.cke_q = link.cke;
      if (dram_reg.sr || dram_reg.pd) begin
        if (dram_reg.sr && !dram_reg.ignore) begin
          dram_next.cnt = dram_reg.cnt + 1'b1;
          if (dram_next.cnt == T_CKSRE) begin
            dram_next.ignore = 1'b1;
          end
        end
        // Only CKE is watched here; exit needs no clock phase relation
        if (link.cke) begin
          dram_next.sr = 1'b0;
          dram_next.pd = 1'b0;
          dram_next.ignore = 1'b0;
          dram_next.cnt = '0;
        end
      end else if (dram_reg.cke_q && !link.cke) begin
        dram_next.sr = (cmd == CMD_REF);
        dram_next.pd = (cmd != CMD_REF);
      end else if (link.cke && cmd == CMD_MRS && link.ba == BA_MR1) begin
        dram_next.dll_off = link.addr[MR1_DLL_BIT];
        dram_next.level = link.addr[MR1_LEVEL_BIT];
        dram_next.qoff = link.addr[MR1_QOFF_BIT];
        dram_next.rtt_nom = link.addr[MR1_RTT_BIT0] ||
          link.addr[MR1_RTT_BIT1] || link.addr[MR1_RTT_BIT2];
      end
      // Termination is never on in self refresh
      dram_next.sterm = !dram_next.sr && link.odt &&
        (dram_next.level || dram_next.rtt_nom);
      dram_next.dterm = !dram_next.sr && !dram_next.level && link.odt &&
        dram_next.rtt_nom;
      dram_next.dq_oe_n = !(dram_next.level && !dram_next.qoff);
    end
  end

  always_ff @(posedge link.ck) begin
    if (link_rst) begin
      dram_reg <= DRAM_RST;
    end else begin
      dram_reg <= dram_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The strobe edge is the sampling clock itself, so the clock level is
  // caught here with no intervening logic
  always_ff @(posedge link.upper_lane_strobe_pair) begin
    fb_upper <= link.ck;
  end

  always_ff @(posedge link.lower_lane_strobe_pair) begin
    fb_lower <= link.ck;
  end

  assign link.dq_o = {{LANE_W{fb_upper}}, {LANE_W{fb_lower}}};
  assign link.dq_oe_n = dram_reg.dq_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  dlwl_sync #(.W(6)) u_status_sync (
    .clk(sys_clk),
    .rst(rst),
    .en(clk_en),
    .d({!dram_reg.dll_off, dram_reg.level, dram_reg.sr, dram_reg.ignore,
      dram_reg.sterm, dram_reg.dterm}),
    .q({dll_enabled, level_mode, in_self_refresh, clock_ignored,
      strobe_term_on, data_term_on})
  );
endmodule

// File: sim/dlwl_monitor.sv
`timescale 1ns/1ns
module dlwl_monitor
  import dlwl_pkg::*;
(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Command side of the link
  input wire logic ck,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic odt,
  // Leveling strobes and feedback
  input wire logic upper_lane_strobe_pair,
  input wire logic lower_lane_strobe_pair,
  input wire logic strobe_oe_n,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic dq_oe_n
);
  localparam int LOW_MIN = T_CKSRE + T_CKSRX - 1;
  logic ck_q;
  logic ck_rise;
  logic is_mrs;
  logic is_mr1;
  logic [CNT_W-1:0] run_reg;
  logic [CNT_W-1:0] last_reg;
  logic [CNT_W-1:0] age_reg;
  logic [CNT_W-1:0] low_reg;

  assign ck_rise = ck && !ck_q;
  assign is_mrs = {cs_n, ras_n, cas_n, we_n} == CMD_MRS;
  assign is_mr1 = ck_rise && cke && reset_n && is_mrs && ba == BA_MR1;

  // Half-period lengths counted in sys_clk cycles, link-clock ages in link clock rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ck_q <= 1'b0;
      run_reg <= '0;
      last_reg <= '0;
      age_reg <= '1;
      low_reg <= '0;
    end else begin
      ck_q <= ck;
      if (ck != ck_q) begin
        last_reg <= run_reg;
        run_reg <= 10'h001;
      end else begin
        run_reg <= run_reg + 10'h001;
      end
      if (ck_rise && is_mrs)
        age_reg <= '0;
      else if (ck_rise && age_reg != '1)
        age_reg <= age_reg + 10'h001;
      if (cke)
        low_reg <= '0;
      else if (ck_rise)
        low_reg <= low_reg + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  level_cmd_a: assert property (!strobe_oe_n |-> is_mrs || {
    cs_n, ras_n, cas_n, we_n} == CMD_NOP) else $error("bad level cmd");
  pd_odt_low_a: assert property (!cke |-> !odt)
    else $error("odt high in power-down");
  // A clock that stops also counts as a change, so clk_en stays high
  ck_steady_a: assert property (ck != ck_q && cke && reset_n
    |-> run_reg == last_reg) else $error("clock changed with cke high");
  upper_fb_a: assert property ($rose(upper_lane_strobe_pair)
    && $stable(ck) && !dq_oe_n |-> dq_o[8] == ck)
    else $error("upper feedback wrong");
  lower_fb_a: assert property ($rose(lower_lane_strobe_pair)
    && $stable(ck) && !dq_oe_n |-> dq_o[0] == ck)
    else $error("lower feedback wrong");
  level_enter_a: assert property (is_mr1 && addr[MR1_LEVEL_BIT] &&
    !addr[MR1_QOFF_BIT] |-> ##[1:10] !dq_oe_n) else $error("no feedback");
  level_leave_a: assert property (is_mr1 && !addr[MR1_LEVEL_BIT]
    |-> ##[1:10] dq_oe_n) else $error("feedback not released");
  odt_after_mod_a: assert property ($rose(odt)
    |-> age_reg >= T_MOD - 10'h001) else $error("odt too early");
  cke_low_span_a: assert property ($rose(cke) && reset_n
    |-> low_reg >= LOW_MIN) else $error("cke low too short");

  cover property ($rose(cke) && reset_n && low_reg >= LOW_MIN);
  cover property ($fell(dq_oe_n));
  cover property ($rose(odt));
endmodule

// File: sim/tb.sv
`timescale 1ns/1ns
module tb
  import dlwl_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] req_v = 4'h0;
  logic zqcl_en = 1'b0;
  logic busy, done, dll_is_off, slow_clk, level_ok;
  logic [PH_W-1:0] delay_upper, delay_lower;
  logic dll_enabled, level_mode, in_self_refresh, clock_ignored;
  logic strobe_term_on, data_term_on;
  logic [31:0] seed = 32'h00017699;
  int fails = 0;
  int total_checks = 0;
  bit off_m, slow_m, sr_seen, ign_seen, su_q, sl_q;
  bit fb_u[$];
  bit fb_l[$];

  always #20 sys_clk = ~sys_clk;

  dlwl_if link();
  dlwl_ctrl u_dlwl_ctrl (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .req_dll_off(req_v[0]), .req_dll_on(req_v[1]), .req_pd_freq(req_v[2]),
    .req_level(req_v[3]), .zqcl_en(zqcl_en), .busy(busy), .done(done),
    .dll_is_off(dll_is_off), .slow_clk(slow_clk), .level_ok(level_ok),
    .delay_upper(delay_upper), .delay_lower(delay_lower), .link(link));
  dlwl_dram u_dlwl_dram (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .dll_enabled(dll_enabled), .level_mode(level_mode),
    .in_self_refresh(in_self_refresh), .clock_ignored(clock_ignored),
    .strobe_term_on(strobe_term_on), .data_term_on(data_term_on),
    .link(link));
  dlwl_monitor u_dlwl_monitor (.sys_clk(sys_clk), .rst(rst), .ck(link.ck),
    .reset_n(link.reset_n), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
    .addr(link.addr), .odt(link.odt),
    .upper_lane_strobe_pair(link.upper_lane_strobe_pair),
    .lower_lane_strobe_pair(link.lower_lane_strobe_pair),
    .strobe_oe_n(link.strobe_oe_n), .dq_o(link.dq_o),
    .dq_oe_n(link.dq_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Feedback starts as a one, so a high sample at delay 0 is no edge
  function automatic logic [4:0] lvl_exp(input bit q[$], input int half);
    bit p;
    p = 1'b1;
    for (int i = 0; i < q.size(); i++) begin
      if (q[i] && !p)
        return {1'b1, 4'(i)};
      p = q[i];
    end
    return {1'b0, 4'(2 * half - 1)};
  endfunction

  // Feedback is read one sys_clk after the strobe rise, as the wire shows it
  always @(posedge sys_clk) begin
    if (link.upper_lane_strobe_pair && !su_q) begin
      fb_u.push_back(link.dq[8]);
      check(level_mode, 1'b1);
      check(strobe_term_on, 1'b1);
      check(data_term_on, 1'b0);
    end
    if (link.lower_lane_strobe_pair && !sl_q)
      fb_l.push_back(link.dq[0]);
    su_q = link.upper_lane_strobe_pair;
    sl_q = link.lower_lane_strobe_pair;
    if (in_self_refresh === 1'b1)
      sr_seen = 1'b1;
    if (clock_ignored === 1'b1)
      ign_seen = 1'b1;
  end

  task automatic launch(input logic [3:0] m);
    @(negedge sys_clk);
    sr_seen = 1'b0;
    ign_seen = 1'b0;
    fb_u.delete();
    fb_l.delete();
    seed = xs(seed);
    zqcl_en = seed[3];
    req_v = m;
    @(negedge sys_clk);
    req_v = 4'h0;
  endtask

  task automatic finish_op(input int op);
    bit got;
    logic [4:0] eu, el;
    int half;
    got = 1'b0;
    for (int i = 0; i < 8000 && !got; i++) begin
      @(posedge sys_clk);
      #1;
      got = (done === 1'b1);
    end
    check(got, 1'b1);
    half = slow_m ? HALF_SLOW : HALF_FAST;
    case (op)
      0, 1: begin
        off_m = (op == 0);
        slow_m = off_m;
        check(sr_seen, 1'b1);
        check(ign_seen, 1'b1);
      end
      2: begin
        slow_m = !slow_m;
        check(sr_seen, 1'b0);
        check(ign_seen, 1'b0);
      end
      default: begin
        eu = lvl_exp(fb_u, half);
        el = lvl_exp(fb_l, half);
        check(delay_upper, eu[3:0]);
        check(delay_lower, el[3:0]);
        check(level_ok, eu[4] && el[4]);
      end
    endcase
    repeat (4) @(posedge sys_clk);
    #1;
    check(dll_enabled, !off_m);
    check(dll_is_off, off_m);
    check(slow_clk, slow_m);
    check(level_mode, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int op;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 400 && busy !== 1'b0; i++)
      @(posedge sys_clk);
    check(busy, 1'b0);
    check(dll_enabled, 1'b1);
    launch(4'h1);
    finish_op(0);
    launch(4'h1);
    repeat (60) @(negedge sys_clk);
    check(busy, 1'b0);
    check(dll_enabled, 1'b0);
    // Leveling queued behind a power-down change with the DLL still off
    launch(4'h4);
    repeat (20) @(negedge sys_clk);
    req_v = 4'h8;
    @(negedge sys_clk);
    req_v = 4'h0;
    finish_op(2);
    finish_op(3);
    for (int n = 0; n < 10; n++) begin
      seed = xs(seed);
      op = int'(seed[1:0]);
      launch(4'h1 << op);
      if ((op == 0 && off_m) || (op == 1 && !off_m)) begin
        repeat (60) @(negedge sys_clk);
        check(busy, 1'b0);
      end else begin
        finish_op(op);
      end
    end
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    fails++;
    stop_test();
  end
endmodule
